// >>> rtl/clkgen_pkg.sv
package clkgen_pkg;

    // register port widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // register offset and reset value
    localparam logic [ADDR_W-1:0] ADDR_CPU_CLOCK_CTRL  = 8'h00;
    localparam logic [DATA_W-1:0] CPU_CLOCK_CTRL_RESET = 8'h04;
    localparam logic [DATA_W-1:0] CPU_CLOCK_CTRL_WMASK = 8'hd7;

    // field positions
    localparam int MAIN_OSC_STOP_BIT    = 7;
    localparam int FEEDBACK_RES_BIT     = 6;
    localparam int CLOCK_STATUS_BIT     = 5;
    localparam int CLOCK_SOURCE_BIT     = 4;
    localparam int DIV_SEL_MSB          = 2;
    localparam int DIV_SEL_W            = 3;

    // divider select limits
    localparam logic [DIV_SEL_W-1:0] DIV_SEL_MAX = 3'h4;

    // oscillation stabilization, counted in main oscillator edges
    localparam int STAB_EDGES_DEFAULT = 131072;
    localparam int STAB_CNT_W         = 18;

    // subsystem edges per instruction, minus one
    localparam logic [1:0] SUB_INST_LAST = 2'h3;

    // instructions on the old clock before a switchover applies
    localparam int            SWITCH_CNT_W      = 5;
    localparam logic [4:0]    MAIN_SWITCH_INSTR = 5'h10;
    localparam logic [4:0]    SUB_SWITCH_INSTR  = 5'h01;

endpackage

// >>> rtl/osc_edge_sync.sv
module osc_edge_sync
    import clkgen_pkg::*;
(
    // clock and reset
    input  wire logic i_clock,
    input  wire logic i_rst_n,
    // oscillator pin
    input  wire logic i_pin,
    // rising edge pulse
    output logic      o_edge
);
    import clkgen_pkg::*;

    logic stage1;
    logic stage2;
    logic stage3;

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
        end else begin
            stage1 <= i_pin;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    assign o_edge = stage2 && !stage3;

endmodule

// >>> rtl/main_divider.sv
module main_divider
    import clkgen_pkg::*;
(
    // clock and reset
    input  wire logic                 i_clock,
    input  wire logic                 i_rst_n,
    // control
    input  wire logic                 i_clear,
    input  wire logic                 i_edge,
    input  wire logic [DIV_SEL_W-1:0] i_div_sel,
    // ticks
    output logic                      o_inst_tick,
    output logic                      o_periph_tick
);
    import clkgen_pkg::*;

    logic [4:0] count;
    logic [4:0] next_count;
    logic [4:0] mask;

    // low sel+1 bits all ones: divide by 2, 4, 8, 16, 32
    assign mask          = 5'h1f >> (DIV_SEL_MAX - i_div_sel);
    assign o_inst_tick   = i_edge && ((count & mask) == mask);
    assign o_periph_tick = i_edge && count[0];
    assign next_count    = i_clear ? 5'h00 : (i_edge ? count + 5'h01 : count);

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count <= 5'h00;
        end else begin
            count <= next_count;
        end
    end

endmodule

// >>> rtl/dual_oscillator_clock_generator.sv
// Behaviour
// - reset loads control register with 04h
// - main oscillator stopped while reset low
// - five main instruction times via divider field
// - STOP and HALT available on main clock
// - bit 6 disables subsystem feedback resistor
// - subsystem clock: HALT allowed, STOP refused
// - peripherals on main clock, watch/clkout on sub
// - status bit 5 shows active clock
// - main stop bit waits for subsystem switch
// - source bit selects subsystem, main runs on until stop bit set
// - subsystem ignores divider, fixed instruction time
// - watchdog counting halts on subsystem clock
// - STOP, or stop bit on subsystem clock, pulls main output up
// - switchover lags write by some instructions
// - stabilization wait before main clock execution
//
// Local design decisions: the register addresses and the strobed register port.
module dual_oscillator_clock_generator
    import clkgen_pkg::*;
#(
    parameter int STAB_EDGES = STAB_EDGES_DEFAULT
) (
    // clock and reset
    input  wire logic              i_clock,
    input  wire logic              i_rst_n,
    // register port
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic              i_write,
    input  wire logic              i_read,
    output logic      [DATA_W-1:0] o_rdata,
    // oscillator pins
    input  wire logic              i_main_osc_in,
    input  wire logic              i_sub_osc_in,
    // standby requests
    input  wire logic              i_stop_req,
    input  wire logic              i_halt_req,
    input  wire logic              i_wake,
    // oscillator control
    output logic                   o_main_osc_run,
    output logic                   o_main_osc_out_pullup,
    output logic                   o_feedback_resistor_off,
    // clock enables
    output logic                   o_cpu_tick,
    output logic                   o_periph_tick,
    output logic                   o_watch_tick,
    output logic                   o_clkout_tick,
    output logic                   o_wdt_count_en,
    // status
    output logic                   o_cpu_clock_status,
    output logic                   o_halted,
    output logic                   o_stopped
);
    import clkgen_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic [DIV_SEL_W-1:0] div_clamp(input logic [DIV_SEL_W-1:0] sel);
        div_clamp = (sel > DIV_SEL_MAX) ? DIV_SEL_MAX : sel;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state

    logic [DATA_W-1:0]       cpu_clock_ctrl_reg;
    logic                    act_css;
    logic [DIV_SEL_W-1:0]    act_div;
    logic [SWITCH_CNT_W-1:0] switch_cnt;
    logic [STAB_CNT_W-1:0]   stab_cnt;
    logic                    main_stable;
    logic [1:0]              sub_cnt;

    ////////////////////////////////////////////////////////////////////////////
    // register decode

    logic                    reg_hit_wr;
    logic                    reg_hit_rd;
    logic                    main_osc_stop;
    logic                    clock_source_select;
    logic [DIV_SEL_W-1:0]    div_req;
    logic [DATA_W-1:0]       read_value;
    logic [DATA_W-1:0]       next_ctrl;
    logic [DATA_W-1:0]       next_rdata;

    assign reg_hit_wr          = i_write && (i_addr == ADDR_CPU_CLOCK_CTRL);
    assign reg_hit_rd          = i_read && (i_addr == ADDR_CPU_CLOCK_CTRL);
    assign main_osc_stop       = cpu_clock_ctrl_reg[MAIN_OSC_STOP_BIT];
    assign clock_source_select = cpu_clock_ctrl_reg[CLOCK_SOURCE_BIT];
    assign div_req             = div_clamp(cpu_clock_ctrl_reg[DIV_SEL_MSB:0]);
    assign next_ctrl           = reg_hit_wr ? (i_wdata & CPU_CLOCK_CTRL_WMASK)
                                            : cpu_clock_ctrl_reg;
    // status bit is the clock actually in use
    assign read_value          = {cpu_clock_ctrl_reg[7:6], act_css,
                                  cpu_clock_ctrl_reg[4:0]};
    assign next_rdata          = reg_hit_rd ? read_value : 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // oscillator edges and stabilization

    logic main_edge_raw;
    logic main_edge;
    logic sub_edge;
    logic next_run;
    logic next_stable;
    logic [STAB_CNT_W-1:0] next_stab_cnt;
    logic stab_last;

    osc_edge_sync u_main_sync (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_pin   (i_main_osc_in),
        .o_edge  (main_edge_raw)
    );

    osc_edge_sync u_sub_sync (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_pin   (i_sub_osc_in),
        .o_edge  (sub_edge)
    );

    assign main_edge     = main_edge_raw && o_main_osc_run;
    // stop bit only bites once the subsystem clock is active
    assign next_run      = !o_stopped && !(main_osc_stop && act_css);
    assign stab_last     = (stab_cnt == STAB_CNT_W'(STAB_EDGES - 1));
    assign next_stab_cnt = !o_main_osc_run ? '0
                         : (main_edge && !main_stable) ? stab_cnt + 1'b1
                         : stab_cnt;
    assign next_stable   = o_main_osc_run && (main_stable || (main_edge && stab_last));

    ////////////////////////////////////////////////////////////////////////////
    // instruction ticks

    logic main_inst;
    logic periph_raw;
    logic sub_inst;
    logic run_ok;
    logic cpu_tick_int;

    main_divider u_divider (
        .i_clock       (i_clock),
        .i_rst_n       (i_rst_n),
        .i_clear       (!main_stable),
        .i_edge        (main_edge),
        .i_div_sel     (act_div),
        .o_inst_tick   (main_inst),
        .o_periph_tick (periph_raw)
    );

    assign sub_inst     = sub_edge && (sub_cnt == SUB_INST_LAST);
    assign run_ok       = !o_halted && !o_stopped;
    assign cpu_tick_int = run_ok && (act_css ? sub_inst : (main_inst && main_stable));

    ////////////////////////////////////////////////////////////////////////////
    // delayed switchover

    logic                    pend;
    logic                    apply;
    logic [SWITCH_CNT_W-1:0] switch_need;
    logic [SWITCH_CNT_W-1:0] switch_inc;
    logic [SWITCH_CNT_W-1:0] next_switch_cnt;

    assign pend            = (clock_source_select != act_css) || (div_req != act_div);
    assign switch_need     = act_css ? SUB_SWITCH_INSTR : (MAIN_SWITCH_INSTR >> act_div);
    assign switch_inc      = switch_cnt + 5'h01;
    assign apply           = pend && cpu_tick_int && !reg_hit_wr
                           && (switch_inc >= switch_need);
    assign next_switch_cnt = (reg_hit_wr || !pend || apply) ? 5'h00
                           : (cpu_tick_int ? switch_inc : switch_cnt);

    ////////////////////////////////////////////////////////////////////////////
    // standby

    logic stop_ok;
    logic next_stop;
    logic next_halt;

    // STOP refused while the subsystem clock runs the cpu
    assign stop_ok   = i_stop_req && !act_css;
    assign next_stop = stop_ok ? 1'b1 : (i_wake ? 1'b0 : o_stopped);
    assign next_halt = i_halt_req ? 1'b1 : (i_wake ? 1'b0 : o_halted);

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cpu_clock_ctrl_reg <= CPU_CLOCK_CTRL_RESET;
            o_rdata            <= 8'h00;
        end else begin
            cpu_clock_ctrl_reg <= next_ctrl;
            o_rdata            <= next_rdata;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            act_css    <= 1'b0;
            act_div    <= DIV_SEL_MAX;
            switch_cnt <= 5'h00;
        end else begin
            act_css    <= apply ? clock_source_select : act_css;
            act_div    <= apply ? div_req : act_div;
            switch_cnt <= next_switch_cnt;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_main_osc_run        <= 1'b0;
            o_main_osc_out_pullup <= 1'b0;
            stab_cnt              <= '0;
            main_stable           <= 1'b0;
        end else begin
            o_main_osc_run        <= next_run;
            o_main_osc_out_pullup <= !next_run;
            stab_cnt              <= next_stab_cnt;
            main_stable           <= next_stable;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sub_cnt   <= 2'h0;
            o_stopped <= 1'b0;
            o_halted  <= 1'b0;
        end else begin
            sub_cnt   <= sub_edge ? sub_cnt + 2'h1 : sub_cnt;
            o_stopped <= next_stop;
            o_halted  <= next_halt;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_cpu_tick              <= 1'b0;
            o_periph_tick           <= 1'b0;
            o_watch_tick            <= 1'b0;
            o_clkout_tick           <= 1'b0;
            o_wdt_count_en          <= 1'b0;
            o_cpu_clock_status      <= 1'b0;
            o_feedback_resistor_off <= 1'b0;
        end else begin
            o_cpu_tick              <= cpu_tick_int;
            o_periph_tick           <= periph_raw && main_stable;
            o_watch_tick            <= sub_edge;
            o_clkout_tick           <= sub_edge;
            o_wdt_count_en          <= !act_css && main_stable && !o_stopped;
            o_cpu_clock_status      <= act_css;
            o_feedback_resistor_off <= cpu_clock_ctrl_reg[FEEDBACK_RES_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    logic seen_write;

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            seen_write <= 1'b0;
        end else begin
            seen_write <= seen_write || reg_hit_wr;
        end
    end

    sequence s_css_write;
        reg_hit_wr && (i_wdata[CLOCK_SOURCE_BIT] != act_css);
    endsequence

    sequence s_held_css;
        (act_css == $past(act_css));
    endsequence

    property p_reset_value;
        !seen_write |-> (cpu_clock_ctrl_reg == CPU_CLOCK_CTRL_RESET);
    endproperty
    a_reset_value: assert property (p_reset_value) else $error("reset value wrong");
    property p_osc_off_at_release;
        $rose(i_rst_n) |-> !o_main_osc_run;
    endproperty
    a_osc_off_at_release: assert property (p_osc_off_at_release)
        else $error("osc ran in reset");
    property p_main_tick_on_edge;
        (cpu_tick_int && !act_css) |-> (main_edge && main_stable);
    endproperty
    a_main_tick_on_edge: assert property (p_main_tick_on_edge) else $error("off edge");
    property p_stop_taken;
        (i_stop_req && !act_css) |=> o_stopped ##1 o_main_osc_out_pullup;
    endproperty
    a_stop_taken: assert property (p_stop_taken) else $error("STOP not taken");
    property p_stop_refused;
        (i_stop_req && act_css && !o_stopped) |=> !o_stopped;
    endproperty
    a_stop_refused: assert property (p_stop_refused) else $error("STOP on sub taken");
    property p_feedback;
        ##1 (o_feedback_resistor_off == $past(cpu_clock_ctrl_reg[FEEDBACK_RES_BIT]));
    endproperty
    a_feedback: assert property (p_feedback) else $error("feedback control wrong");
    property p_periph_stops;
        !main_stable |=> !o_periph_tick;
    endproperty
    a_periph_stops: assert property (p_periph_stops) else $error("periph tick ran");
    property p_status_read;
        reg_hit_rd |=> (o_rdata[CLOCK_STATUS_BIT] == $past(act_css));
    endproperty
    a_status_read: assert property (p_status_read) else $error("status bit wrong");
    property p_osc_kept;
        (i_rst_n && !act_css && !o_stopped) |=> o_main_osc_run;
    endproperty
    a_osc_kept: assert property (p_osc_kept) else $error("main osc stopped early");
    property p_osc_stops;
        (act_css && main_osc_stop) |=> (!o_main_osc_run && o_main_osc_out_pullup);
    endproperty
    a_osc_stops: assert property (p_osc_stops) else $error("main osc not stopped");
    property p_sub_tick;
        (cpu_tick_int && act_css) |-> (sub_edge && sub_cnt == SUB_INST_LAST);
    endproperty
    a_sub_tick: assert property (p_sub_tick) else $error("sub tick wrong");
    property p_wdt_halt;
        act_css |=> !o_wdt_count_en;
    endproperty
    a_wdt_halt: assert property (p_wdt_halt) else $error("watchdog counts on sub");
    property p_switch_lag;
        s_css_write |=> s_held_css;
    endproperty
    a_switch_lag: assert property (p_switch_lag) else $error("switch not delayed");
    property p_stab_wait;
        (!main_stable && !act_css) |-> !cpu_tick_int;
    endproperty
    a_stab_wait: assert property (p_stab_wait) else $error("cpu ran before stable");

endmodule

// >>> test/osc_source.sv
module osc_source (
    // oscillator control
    input  wire logic i_main_run,
    // oscillator pins
    output logic      o_main_osc_in,
    output logic      o_sub_osc_in
);
    timeunit 1ns;
    timeprecision 1ps;

    localparam int MAIN_HALF = 20;
    localparam int SUB_HALF  = 100;

    ////////////////////////////////////////////////////////////////////////////////
    // main crystal, stalls low once its enable drops
    initial begin
        o_main_osc_in = 1'b0;
        #3;
        forever begin
            #MAIN_HALF;
            o_main_osc_in = i_main_run ? ~o_main_osc_in : 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // watch crystal, never stops
    initial begin
        o_sub_osc_in = 1'b0;
        #7;
        forever begin
            #SUB_HALF;
            o_sub_osc_in = ~o_sub_osc_in;
        end
    end
endmodule

// >>> test/tb_dual_oscillator_clock_generator.sv
module tb_dual_oscillator_clock_generator;
    timeunit 1ns;
    timeprecision 1ps;
    import clkgen_pkg::*;

    logic              i_clock = 1'b0;
    logic              i_rst_n;
    logic [ADDR_W-1:0] i_addr;
    logic [DATA_W-1:0] i_wdata;
    logic              i_write, i_read, i_stop_req, i_halt_req, i_wake;
    logic [DATA_W-1:0] o_rdata;
    logic              i_main_osc_in, i_sub_osc_in;
    logic              o_main_osc_run, o_main_osc_out_pullup, o_feedback_resistor_off;
    logic              o_cpu_tick, o_periph_tick, o_watch_tick, o_clkout_tick;
    logic              o_wdt_count_en, o_cpu_clock_status, o_halted, o_stopped;
    int                fails = 0;
    int                checks = 0;

    always #4 i_clock = ~i_clock;

    dual_oscillator_clock_generator #(.STAB_EDGES(8)) uut (
        .i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata),
        .i_main_osc_in(i_main_osc_in), .i_sub_osc_in(i_sub_osc_in),
        .i_stop_req(i_stop_req), .i_halt_req(i_halt_req), .i_wake(i_wake),
        .o_main_osc_run(o_main_osc_run), .o_main_osc_out_pullup(o_main_osc_out_pullup),
        .o_feedback_resistor_off(o_feedback_resistor_off), .o_cpu_tick(o_cpu_tick),
        .o_periph_tick(o_periph_tick), .o_watch_tick(o_watch_tick),
        .o_clkout_tick(o_clkout_tick), .o_wdt_count_en(o_wdt_count_en),
        .o_cpu_clock_status(o_cpu_clock_status), .o_halted(o_halted), .o_stopped(o_stopped));

    osc_source u_osc (.i_main_run(o_main_osc_run), .o_main_osc_in(i_main_osc_in),
                      .o_sub_osc_in(i_sub_osc_in));

    ////////////////////////////////////////////////////////////////////////////////
    // helpers
    task automatic test_done();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clock);
        i_write <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_write <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clock);
        i_read <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_read <= 1'b0;
        #1;
        d = o_rdata;
    endtask

    task automatic pulse(input int w);
        @(posedge i_clock);
        if (w == 0) i_stop_req <= 1'b1;
        else if (w == 1) i_halt_req <= 1'b1;
        else i_wake <= 1'b1;
        @(posedge i_clock);
        i_stop_req <= 1'b0;
        i_halt_req <= 1'b0;
        i_wake     <= 1'b0;
        #1;
    endtask

    function automatic logic pick(input int w);
        case (w)
            0: return o_cpu_tick;
            1: return o_periph_tick;
            2: return o_watch_tick;
            3: return o_cpu_clock_status;
            4: return o_main_osc_run;
            default: return o_clkout_tick;
        endcase
    endfunction

    task automatic wait_for(input int w, input logic v, input int bound);
        int n = 0;
        while (pick(w) !== v && n < bound) begin
            @(posedge i_clock);
            #1;
            n++;
        end
        check(16'(pick(w)), 16'(v));
    endtask

    task automatic interval(input int w, output int n);
        wait_for(w, 1'b1, 400);
        @(posedge i_clock);
        #1;
        n = 1;
        while (pick(w) !== 1'b1 && n < 400) begin
            @(posedge i_clock);
            #1;
            n++;
        end
    endtask

    task automatic count(input int w, input int cyc, output int n);
        n = 0;
        repeat (cyc) begin
            @(posedge i_clock);
            #1;
            if (pick(w) === 1'b1) n++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // watchdog
    initial begin
        #400us;
        fails++;
        test_done();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // tests
    initial begin
        logic [7:0] d;
        int         n;
        i_rst_n = 1'b0; i_addr = '0; i_wdata = '0; i_write = 1'b0; i_read = 1'b0;
        i_stop_req = 1'b0; i_halt_req = 1'b0; i_wake = 1'b0;
        @(posedge i_clock);
        #1 check(16'(o_main_osc_run), 16'h0);
        repeat (2) @(posedge i_clock);
        i_rst_n <= 1'b1;
        count(0, 38, n);
        check(n[15:0], 16'h0);
        interval(0, n);
        check(n[15:0], 16'd160);
        rd(8'h00, d);
        check(16'(d), 16'h04);
        rd(8'h01, d);
        check(16'(d), 16'h00);
        wr(8'h00, 8'h2c);
        rd(8'h00, d);
        check(16'(d), 16'h04);
        for (int k = 0; k < 5; k++) begin
            wr(8'h00, 8'(k));
            repeat (18) interval(0, n);
            interval(0, n);
            check(n[15:0], 16'(10 << k));
        end
        wr(8'h00, 8'h00);
        repeat (3) interval(0, n);
        wr(8'h00, 8'h04);
        interval(0, n);
        check(n[15:0], 16'd10);
        repeat (18) interval(0, n);
        interval(1, n);
        check(n[15:0], 16'd10);
        wr(8'h00, 8'h14);
        wait_for(3, 1'b1, 1000);
        rd(8'h00, d);
        check(16'(d), 16'h34);
        wr(8'h00, 8'h10);
        repeat (3) interval(0, n);
        interval(0, n);
        check(n[15:0], 16'd100);
        check(16'(o_wdt_count_en), 16'h0);
        interval(2, n);
        check(n[15:0], 16'd25);
        interval(5, n);
        check(n[15:0], 16'd25);
        pulse(0);
        check(16'(o_stopped), 16'h0);
        pulse(1);
        check(16'(o_halted), 16'h1);
        pulse(2);
        check(16'(o_halted), 16'h0);
        wr(8'h00, 8'hd0);
        wait_for(4, 1'b0, 4);
        check(16'(o_main_osc_out_pullup), 16'h1);
        check(16'(o_feedback_resistor_off), 16'h1);
        count(1, 100, n);
        check(n[15:0], 16'h0);
        wr(8'h00, 8'h04);
        wait_for(3, 1'b0, 1000);
        interval(0, n);
        check(16'(o_wdt_count_en), 16'h1);
        check(16'(o_main_osc_out_pullup), 16'h0);
        wr(8'h00, 8'h84);
        count(4, 300, n);
        check(n[15:0], 16'd300);
        wr(8'h00, 8'h94);
        wait_for(4, 1'b0, 1000);
        check(16'(o_cpu_clock_status), 16'h1);
        wr(8'h00, 8'h04);
        wait_for(3, 1'b0, 1000);
        interval(0, n);
        pulse(0);
        check(16'(o_stopped), 16'h1);
        @(posedge i_clock);
        #1 check(16'(o_main_osc_out_pullup), 16'h1);
        count(0, 400, n);
        check(n[15:0], 16'h0);
        pulse(2);
        check(16'(o_stopped), 16'h0);
        wait_for(0, 1'b1, 1000);
        pulse(1);
        check(16'(o_halted), 16'h1);
        count(0, 400, n);
        check(n[15:0], 16'h0);
        pulse(2);
        @(posedge i_clock);
        i_rst_n <= 1'b0;
        @(posedge i_clock);
        #1 check(16'(o_main_osc_run), 16'h0);
        @(posedge i_clock);
        i_rst_n <= 1'b1;
        rd(8'h00, d);
        check(16'(d), 16'h04);
        test_done();
    end
endmodule
